//--- lcs_map.svh
// Purpose: Offsets, field positions, codes and reset values of the low-carrier stage
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data
// Notes: Definitions only
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

`define LCS_CTRL_OFS 8'h00
`define LCS_STAT_OFS 8'h04

`define LCS_BIT_OUT_DIS 7
`define LCS_BIT_INVERT 6
`define LCS_BIT_SYNC 5
`define LCS_BIT_UNUSED 4
`define LCS_SEL_MSB 3
`define LCS_SEL_LSB 0

`define LCS_SEL_GROUND 4'h0
`define LCS_SEL_PIN1 4'h1
`define LCS_SEL_PIN2 4'h2
`define LCS_SEL_REFCLK 4'h3
`define LCS_SEL_PWM_BASE 2'h1
`define LCS_SRC_CODES 8

`define LCS_CTRL_RST 8'h00
`define LCS_RESP_OKAY 2'h0
`define LCS_RESP_SLVERR 2'h2

`endif

//--- lcs_pkg.sv
// Purpose: Types shared by the low-carrier stage and its register slave
// Assumes: 8-bit byte addresses, 32-bit data
// Notes: Field names of the bus structs follow the published AXI4-Lite names
package lcs_pkg;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic low_carrier_out_disable;
        logic low_carrier_invert;
        logic low_carrier_sync_enable;
        logic [3:0] low_carrier_source_select;
    } low_carrier_control_t;

    typedef enum logic [2:0] {
        SW_LOW = 3'h1,
        SW_WAIT = 3'h2,
        SW_HIGH = 3'h4
    } switch_state_t;

endpackage : lcs_pkg

//--- pin_sync3.sv
// Purpose: Bring an asynchronous pin level into the system clock domain
// Assumes: Pin may change at any time
// Notes: Output follows only once the second and third stages agree
`timescale 1ns/1ps
module pin_sync3
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // First stage may be metastable, so only s2 and s3 are compared
        if (st_ff.s2 == st_ff.s3)
        begin
            nxt_st.level = st_ff.s3;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.level;

endmodule : pin_sync3

//--- lcs_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the low-carrier register file
// Assumes: One write and one read under way at a time
// Notes: Write strobe fires in the same cycle that both address and data are first held
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_axil_slave
(
    input wire logic clk,
    input wire logic rst,
    input wire lcs_pkg::axil_req_t req,
    output lcs_pkg::axil_rsp_t rsp,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    typedef struct packed {
        logic aw_hold;
        logic [7:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } slave_state_t;

    slave_state_t st_ff;
    slave_state_t nxt_st;
    logic aw_take;
    logic w_take;
    logic ar_take;

    assign aw_take = req.awvalid && !st_ff.aw_hold && !st_ff.bvalid;
    assign w_take = req.wvalid && !st_ff.w_hold && !st_ff.bvalid;
    assign ar_take = req.arvalid && !st_ff.rvalid;
    assign wr_en = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
    assign wr_addr = st_ff.awaddr;
    assign wr_data = st_ff.wdata;
    assign wr_strb = st_ff.wstrb;
    assign rd_addr = req.araddr;

    always_comb
    begin
        nxt_st = st_ff;
        if (aw_take)
        begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.awaddr = req.awaddr;
        end
        if (w_take)
        begin
            nxt_st.w_hold = 1'b1;
            nxt_st.wdata = req.wdata;
            nxt_st.wstrb = req.wstrb;
        end
        if (wr_en)
        begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = wr_ok ? `LCS_RESP_OKAY : `LCS_RESP_SLVERR;
        end
        else if (st_ff.bvalid && req.bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (ar_take)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_data;
            nxt_st.rresp = rd_ok ? `LCS_RESP_OKAY : `LCS_RESP_SLVERR;
        end
        else if (st_ff.rvalid && req.rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    always_comb
    begin
        rsp.awready = !st_ff.aw_hold && !st_ff.bvalid;
        rsp.wready = !st_ff.w_hold && !st_ff.bvalid;
        rsp.bvalid = st_ff.bvalid;
        rsp.bresp = st_ff.bresp;
        rsp.arready = !st_ff.rvalid;
        rsp.rvalid = st_ff.rvalid;
        rsp.rdata = st_ff.rdata;
        rsp.rresp = st_ff.rresp;
    end

endmodule : lcs_axil_slave

//--- modulator_low_carrier_select.sv
// Purpose: Low-carrier selection stage of a data signal modulator
// Assumes: CLK_SYS 100 MHz; PWM and reference clock inputs are on CLK_SYS
// Notes: Carrier pins are asynchronous and pass a three-stage synchroniser
// Notes on behaviour
// [RL1] Output-disable bit 7 set stops selected source driving its output pin.
// [RL2] Polarity bit 6 set inverts the selected low carrier.
// [RL3] Sync bit 5 set delays low-to-high switch until a carrier falling edge.
// [RL4] Software should enable sync; unsynchronised switches may narrow pulses.
// [RL5] Carrier source comes from the 4-bit select field, bits 3 to 0.
// [RL6] Code 0111 is PWM unit four, 0110 unit three, PWM mode only; upper codes none.
// [RL7] Bit 4 reads zero; writable fields start unknown, kept over other resets. Here RST loads zero into them.
`timescale 1ns/1ps
`include "lcs_map.svh"
module modulator_low_carrier_select
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire lcs_pkg::axil_req_t AXI_REQ,
    output lcs_pkg::axil_rsp_t AXI_RSP,
    input wire logic CARRIER_PIN1,
    input wire logic CARRIER_PIN2,
    input wire logic REF_CLOCK_SIG,
    input wire logic [3:0] PWM_OUT,
    input wire logic [3:0] PWM_MODE,
    input wire logic SWITCH_REQ,
    output logic LOW_CARRIER,
    output logic SWITCH_GRANT,
    output logic [7:0] SRC_DRIVE_EN
);

    typedef struct packed {
        lcs_pkg::low_carrier_control_t ctrl;
        logic carrier;
        logic carrier_prev;
        lcs_pkg::switch_state_t sw;
        logic [`LCS_SRC_CODES-1:0] drive_en;
    } stage_state_t;

    stage_state_t st_ff;
    stage_state_t nxt_st;

    logic pin1_lvl;
    logic pin2_lvl;
    logic src_raw;
    logic carrier_fall;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [7:0] ctrl_byte;
    logic [`LCS_SRC_CODES-1:0] drive_calc;

    pin_sync3 u_sync_pin1
    (
        .clk(CLK_SYS),
        .rst(RST),
        .pin(CARRIER_PIN1),
        .level(pin1_lvl)
    );

    pin_sync3 u_sync_pin2
    (
        .clk(CLK_SYS),
        .rst(RST),
        .pin(CARRIER_PIN2),
        .level(pin2_lvl)
    );

    lcs_axil_slave u_regs
    (
        .clk(CLK_SYS),
        .rst(RST),
        .req(AXI_REQ),
        .rsp(AXI_RSP),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Source mux; PWM units count only while in PWM output mode
    always_comb
    begin
        src_raw = 1'b0;
        if (st_ff.ctrl.low_carrier_source_select == `LCS_SEL_PIN1) // RL5
        begin
            src_raw = pin1_lvl;
        end
        else if (st_ff.ctrl.low_carrier_source_select == `LCS_SEL_PIN2)
        begin
            src_raw = pin2_lvl;
        end
        else if (st_ff.ctrl.low_carrier_source_select == `LCS_SEL_REFCLK)
        begin
            src_raw = REF_CLOCK_SIG;
        end
        else if (st_ff.ctrl.low_carrier_source_select[3:2] == `LCS_SEL_PWM_BASE)
        begin
            src_raw = PWM_OUT[st_ff.ctrl.low_carrier_source_select[1:0]]
                & PWM_MODE[st_ff.ctrl.low_carrier_source_select[1:0]]; // RL6
        end
    end

    // Per-source pin drive gate; only the selected source is silenced
    genvar k;
    generate
        for (k = 0; k < `LCS_SRC_CODES; k = k + 1)
        begin : g_drive
            assign drive_calc[k] = !(st_ff.ctrl.low_carrier_out_disable
                && (st_ff.ctrl.low_carrier_source_select == 4'(k))); // RL1
        end
    endgenerate

    assign carrier_fall = st_ff.carrier_prev && !st_ff.carrier;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.carrier = src_raw ^ st_ff.ctrl.low_carrier_invert; // RL2
        nxt_st.carrier_prev = st_ff.carrier;
        nxt_st.drive_en = drive_calc;
        if (wr_en && wr_ok && wr_strb[0])
        begin
            nxt_st.ctrl.low_carrier_out_disable = wr_data[`LCS_BIT_OUT_DIS];
            nxt_st.ctrl.low_carrier_invert = wr_data[`LCS_BIT_INVERT];
            nxt_st.ctrl.low_carrier_sync_enable = wr_data[`LCS_BIT_SYNC];
            nxt_st.ctrl.low_carrier_source_select = wr_data[`LCS_SEL_MSB:`LCS_SEL_LSB]; // RL5
        end
        case (st_ff.sw)
            lcs_pkg::SW_LOW:
            begin
                if (SWITCH_REQ)
                begin
                    // Sync off lets the switch through at once
                    nxt_st.sw = st_ff.ctrl.low_carrier_sync_enable ? lcs_pkg::SW_WAIT
                        : lcs_pkg::SW_HIGH; // RL3
                end
            end
            lcs_pkg::SW_WAIT:
            begin
                if (!SWITCH_REQ)
                begin
                    nxt_st.sw = lcs_pkg::SW_LOW;
                end
                else if (carrier_fall || !st_ff.ctrl.low_carrier_sync_enable)
                begin
                    nxt_st.sw = lcs_pkg::SW_HIGH; // RL3
                end
            end
            lcs_pkg::SW_HIGH:
            begin
                if (!SWITCH_REQ)
                begin
                    nxt_st.sw = lcs_pkg::SW_LOW;
                end
            end
            default:
            begin
                nxt_st.sw = lcs_pkg::SW_LOW;
            end
        endcase
    end

    // Power-on value is unknown by nature; a defined zero is the safe pick here
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_ff.ctrl <= lcs_pkg::low_carrier_control_t'(7'(`LCS_CTRL_RST)); // RL7
            st_ff.carrier <= 1'b0;
            st_ff.carrier_prev <= 1'b0;
            st_ff.sw <= lcs_pkg::SW_LOW;
            st_ff.drive_en <= '1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wr_ok = (wr_addr == `LCS_CTRL_OFS);
    assign rd_ok = (rd_addr == `LCS_CTRL_OFS) || (rd_addr == `LCS_STAT_OFS);

    assign ctrl_byte = {st_ff.ctrl.low_carrier_out_disable, st_ff.ctrl.low_carrier_invert,
        st_ff.ctrl.low_carrier_sync_enable, 1'b0, st_ff.ctrl.low_carrier_source_select}; // RL7

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (rd_addr == `LCS_CTRL_OFS)
        begin
            rd_data = {24'h00_0000, ctrl_byte};
        end
        else if (rd_addr == `LCS_STAT_OFS)
        begin
            rd_data = {16'h0000, st_ff.drive_en, 4'h0, st_ff.sw == lcs_pkg::SW_WAIT,
                st_ff.sw == lcs_pkg::SW_HIGH, src_raw, st_ff.carrier};
        end
    end

    assign LOW_CARRIER = st_ff.carrier;
    assign SWITCH_GRANT = (st_ff.sw == lcs_pkg::SW_HIGH);
    assign SRC_DRIVE_EN = st_ff.drive_en;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    a_drive_gated: assert property (st_ff.ctrl.low_carrier_out_disable
        |=> !SRC_DRIVE_EN[$past(st_ff.ctrl.low_carrier_source_select[2:0])]
            || $past(st_ff.ctrl.low_carrier_source_select[3])) // RL1
        else $error("Selected source still drives its pin while disabled");

    a_drive_open: assert property (!st_ff.ctrl.low_carrier_out_disable
        |=> SRC_DRIVE_EN == 8'hFF) // RL1
        else $error("Pin drive dropped while output disable is clear");

    a_carrier_polarity: assert property (1'b1
        |=> LOW_CARRIER == ($past(src_raw) ^ $past(st_ff.ctrl.low_carrier_invert))) // RL2
        else $error("Low carrier does not follow source and polarity");

    a_sync_holds: assert property (st_ff.sw == lcs_pkg::SW_WAIT && SWITCH_REQ
        && st_ff.ctrl.low_carrier_sync_enable && !carrier_fall |=> !SWITCH_GRANT) // RL3
        else $error("Switch granted without a falling carrier edge");

    a_sync_edge_grant: assert property (st_ff.sw == lcs_pkg::SW_WAIT && SWITCH_REQ
        && carrier_fall |=> SWITCH_GRANT) // RL3
        else $error("Falling edge seen but switch not granted");

    a_nosync_fast: assert property (!st_ff.ctrl.low_carrier_sync_enable
        && SWITCH_REQ |=> ##1 SWITCH_GRANT || !$past(SWITCH_REQ)
            || $past(st_ff.ctrl.low_carrier_sync_enable)) // RL3
        else $error("Unsynchronised switch was delayed");

    a_select_write: assert property (wr_en && wr_ok && wr_strb[0]
        |=> st_ff.ctrl.low_carrier_source_select == $past(wr_data[3:0])) // RL5
        else $error("Select field did not take the written value");

    a_pwm_mode_gate: assert property (st_ff.ctrl.low_carrier_source_select[3:2] == 2'h1
        && !PWM_MODE[st_ff.ctrl.low_carrier_source_select[1:0]] |-> !src_raw) // RL6
        else $error("PWM unit passed while not in PWM output mode");

    a_reserved_quiet: assert property (st_ff.ctrl.low_carrier_source_select[3]
        ##1 st_ff.ctrl.low_carrier_source_select[3] |-> LOW_CARRIER
            == st_ff.ctrl.low_carrier_invert || $changed(st_ff.ctrl.low_carrier_invert)) // RL6
        else $error("Reserved select code connected a channel");

    a_bit4_zero: assert property (AXI_RSP.rvalid && $past(rd_addr) == 8'h00
        && $rose(AXI_RSP.rvalid) |-> !AXI_RSP.rdata[4]) // RL7
        else $error("Unimplemented bit read back as one");

endmodule : modulator_low_carrier_select

//--- tb_low_carrier.sv
// Purpose: Self-checking bench for the low-carrier selection stage
// Assumes: Register map and response codes from lcs_map.svh; pins settle within 6 cycles
// Notes: Table rows cover source codes, inversion and drive gating; switch and bus cases follow
`timescale 1ns/1ps
`include "lcs_map.svh"
module testbench;
    typedef struct {
        logic [7:0] ctrl;
        logic [10:0] src;
        logic lc;
        logic [7:0] en;
    } row_t;
    logic clk_sys;
    logic rst;
    lcs_pkg::axil_req_t req;
    lcs_pkg::axil_rsp_t rsp;
    // Sources packed as pin1, pin2, refclk, pwm_out[3:0], pwm_mode[3:0]
    logic [10:0] src;
    logic switch_req;
    logic low_carrier;
    logic switch_grant;
    logic [7:0] drive_en;
    int n_mismatch;
    int comparisons;
    logic [31:0] rd;
    row_t rows [17];

    modulator_low_carrier_select dut_u
    (
        .CLK_SYS(clk_sys),
        .RST(rst),
        .AXI_REQ(req),
        .AXI_RSP(rsp),
        .CARRIER_PIN1(src[10]),
        .CARRIER_PIN2(src[9]),
        .REF_CLOCK_SIG(src[8]),
        .PWM_OUT(src[7:4]),
        .PWM_MODE(src[3:0]),
        .SWITCH_REQ(switch_req),
        .LOW_CARRIER(low_carrier),
        .SWITCH_GRANT(switch_grant),
        .SRC_DRIVE_EN(drive_en)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic timed_out(input string name);
        n_mismatch++;
        $display("Error %s expected answer seen timeout", name);
        summarize();
    endtask : timed_out

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        logic aw_p;
        logic w_p;
        logic aw_hs;
        logic w_hs;
        logic seen;
        logic [1:0] resp;
        aw_p = 1'b1;
        w_p = 1'b1;
        seen = 1'b0;
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (k = 0; k < 50 && (aw_p || w_p); k++)
        begin
            #1;
            aw_hs = aw_p && rsp.awready === 1'b1;
            w_hs = w_p && rsp.wready === 1'b1;
            @(posedge clk_sys);
            if (aw_hs)
            begin
                req.awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_hs)
            begin
                req.wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        for (k = 0; k < 50 && !seen; k++)
        begin
            #1;
            seen = rsp.bvalid === 1'b1;
            resp = rsp.bresp;
            @(posedge clk_sys);
        end
        req.bready <= 1'b0;
        if (!seen)
            timed_out("bvalid");
        chk("bresp", {30'h0, er}, {30'h0, resp});
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
        int k;
        logic ar_p;
        logic seen;
        logic [1:0] resp;
        ar_p = 1'b1;
        seen = 1'b0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (k = 0; k < 50 && ar_p; k++)
        begin
            #1;
            ar_p = rsp.arready !== 1'b1;
            @(posedge clk_sys);
        end
        req.arvalid <= 1'b0;
        for (k = 0; k < 50 && !seen; k++)
        begin
            #1;
            seen = rsp.rvalid === 1'b1;
            resp = rsp.rresp;
            rd = rsp.rdata;
            @(posedge clk_sys);
        end
        req.rready <= 1'b0;
        if (!seen)
            timed_out("rvalid");
        chk("rresp", {30'h0, er}, {30'h0, resp});
    endtask : axi_read

    initial
    begin
        int i;
        int k;
        logic hi;
        n_mismatch = 0;
        comparisons = 0;
        rst = 1'b1;
        req = '0;
        src = 11'h000;
        switch_req = 1'b0;
        rows = '{'{8'h00, 11'h7FF, 1'b0, 8'hFF}, '{8'h01, 11'h400, 1'b1, 8'hFF}, '{8'h02, 11'h200, 1'b1, 8'hFF},
            '{8'h03, 11'h100, 1'b1, 8'hFF}, '{8'h04, 11'h011, 1'b1, 8'hFF}, '{8'h05, 11'h022, 1'b1, 8'hFF},
            '{8'h06, 11'h044, 1'b1, 8'hFF}, '{8'h07, 11'h088, 1'b1, 8'hFF}, '{8'h07, 11'h087, 1'b0, 8'hFF},
            '{8'h07, 11'h07F, 1'b0, 8'hFF}, '{8'h0F, 11'h7FF, 1'b0, 8'hFF}, '{8'h08, 11'h7FF, 1'b0, 8'hFF},
            '{8'h40, 11'h000, 1'b1, 8'hFF}, '{8'h43, 11'h100, 1'b0, 8'hFF}, '{8'h83, 11'h100, 1'b1, 8'hF7},
            '{8'h87, 11'h088, 1'b1, 8'h7F}, '{8'h89, 11'h7FF, 1'b0, 8'hFF}};
        tick(5);
        chk("drive_en in reset", 32'hFF, {24'h0, drive_en});
        chk("grant in reset", 32'h0, {31'h0, switch_grant});
        rst <= 1'b0;
        tick(1);
        axi_read(`LCS_CTRL_OFS, `LCS_RESP_OKAY);
        chk("ctrl after reset", 32'h0, rd);
        $display("reset test done");
        // Row table: source codes, PWM mode gating, inversion, drive gating
        for (i = 0; i < 17; i++)
        begin
            @(posedge clk_sys);
            src <= rows[i].src;
            axi_write(`LCS_CTRL_OFS, {24'h0, rows[i].ctrl}, `LCS_RESP_OKAY);
            tick(6);
            chk("low_carrier", {31'h0, rows[i].lc}, {31'h0, low_carrier});
            chk("drive_en", {24'h0, rows[i].en}, {24'h0, drive_en});
        end
        $display("table test done");
        axi_write(`LCS_CTRL_OFS, 32'h0000_00FF, `LCS_RESP_OKAY);
        axi_read(`LCS_CTRL_OFS, `LCS_RESP_OKAY);
        chk("ctrl readback", 32'hEF, rd);
        axi_write(`LCS_STAT_OFS, 32'h0000_0000, `LCS_RESP_SLVERR);
        axi_write(8'h08, 32'h0000_0000, `LCS_RESP_SLVERR);
        axi_read(8'h08, `LCS_RESP_SLVERR);
        axi_read(`LCS_CTRL_OFS, `LCS_RESP_OKAY);
        chk("ctrl unchanged", 32'hEF, rd);
        $display("register test done");
        // Unsynchronised: a constant carrier has no falling edge, grant must not wait
        @(posedge clk_sys);
        src <= 11'h000;
        axi_write(`LCS_CTRL_OFS, 32'h0000_0003, `LCS_RESP_OKAY);
        switch_req <= 1'b1;
        tick(3);
        chk("grant sync off", 32'h1, {31'h0, switch_grant});
        @(posedge clk_sys);
        switch_req <= 1'b0;
        tick(3);
        chk("grant dropped", 32'h0, {31'h0, switch_grant});
        // Synchronised, plain and inverted: grant only after the carrier falls
        for (i = 0; i < 2; i++)
        begin
            hi = (i == 0);
            @(posedge clk_sys);
            src <= {2'b00, hi, 8'h00};
            axi_write(`LCS_CTRL_OFS, (i == 0) ? 32'h23 : 32'h63, `LCS_RESP_OKAY);
            switch_req <= 1'b1;
            tick(8);
            chk("grant held off", 32'h0, {31'h0, switch_grant});
            @(posedge clk_sys);
            src <= {2'b00, ~hi, 8'h00};
            for (k = 0; k < 10 && switch_grant !== 1'b1; k++)
                tick(1);
            chk("grant after fall", 32'h1, {31'h0, switch_grant});
            @(posedge clk_sys);
            switch_req <= 1'b0;
            tick(3);
        end
        $display("switch test done");
        summarize();
    end
endmodule : testbench
